/* File: design/rtc_pkg.sv */
// rtc_pkg: register map, field positions, reset values and codes of the
// transmitter configuration register bank.
// assumes: included before every design file of the bank.
package rtc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] RTC_CHAN12_INTEGER       = 8'h04;
  localparam logic [7:0] RTC_CHAN3_FRACTION_HIGH  = 8'h05;
  localparam logic [7:0] RTC_CHAN3_FRACTION_LOW   = 8'h06;
  localparam logic [7:0] RTC_CHAN4_FRACTION_HIGH  = 8'h07;
  localparam logic [7:0] RTC_CHAN4_FRACTION_LOW   = 8'h08;
  localparam logic [7:0] RTC_CHAN34_INTEGER       = 8'h09;
  localparam logic [7:0] RTC_OUT_DIVIDER_AND_SLEW = 8'h0a;
  localparam logic [7:0] RTC_FSK_DEVIATION_CODE   = 8'h0b;
  localparam logic [7:0] RTC_MODULATION_SET_A     = 8'h0c;
  localparam logic [7:0] RTC_MODULATION_SET_B     = 8'h0d;
  localparam logic [7:0] RTC_DUTY_AND_LOW_LEVEL   = 8'h0e;
  localparam logic [7:0] RTC_ASK_RAMP_CONTROL     = 8'h0f;
  localparam logic [7:0] RTC_FSK_RAMP_CONTROL     = 8'h10;
  localparam logic [7:0] RTC_DIVIDER_COMPARE      = 8'h11;
  localparam logic [7:0] RTC_CLOCK_SOURCE_SCALERS = 8'h12;
  localparam logic [7:0] RTC_UNDERVOLT_ANT_TRIM   = 8'h13;
  localparam logic [7:0] RTC_TRANSMIT_STATUS      = 8'h14;
  localparam logic [7:0] RTC_FIRST_ADDR           = 8'h04;
  localparam int         RTC_NUM_REGS             = 17;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RTC_REG_RESET      = 8'h00;
  localparam logic [4:0] RTC_INT_BASE       = 5'h10;
  localparam logic [7:0] RTC_TRIM_MASK      = 8'h7f;
  localparam int         RTC_ODD_CHAN_LSB   = 4;
  localparam int         RTC_MOD_TYPE_BIT   = 7;
  localparam int         RTC_RANGE_BIT      = 6;
  localparam int         RTC_DEV_QUAD_BIT   = 7;
  localparam int         RTC_DEV_DOUBLE_BIT = 6;
  localparam int         RTC_EDGE_LSB       = 4;
  localparam int         RTC_DUTY_LSB       = 6;
  localparam int         RTC_SRC_LSB        = 5;
  localparam int         RTC_PSC_LSB        = 2;
  localparam int         RTC_UNDERVOLT_THRESHOLD_SEL_LSB       = 5;
  localparam int         RTC_COUNT_LSB      = 4;
  localparam int         RTC_OSC_BIT        = 3;
  localparam int         RTC_UV_BIT         = 2;
  localparam int         RTC_VCO_BIT        = 1;
  localparam int         RTC_LOCK_BIT       = 0;

  // fixed divide by 16 of the reference for source code 000b
  localparam int         RTC_REF_DIV_LOG2   = 4;

  // duty codes, lower band and upper band
  localparam logic [1:0] RTC_DUTY_50 = 2'h0;
  localparam logic [1:0] RTC_DUTY_45 = 2'h1;
  localparam logic [1:0] RTC_DUTY_36 = 2'h2;
  localparam logic [1:0] RTC_DUTY_30 = 2'h3;

  // clock pin source selections, low two bits of the source code
  typedef enum logic [1:0] {
    RTC_SRC_REF16   = 2'h0,
    RTC_SRC_PRESCL  = 2'h1,
    RTC_SRC_DIVIDED = 2'h2,
    RTC_SRC_INVERT  = 2'h3
  } rtc_src_e;

endpackage

/* File: design/rtc_reg_mem.sv */
// rtc_reg_mem: small byte store for the plain read/write registers,
// with registered read data.
// assumes: one write and one read port, synchronous reset to zero.
`timescale 1ns/1ns
module rtc_reg_mem
  import rtc_pkg::*;
#(
  parameter int DEPTH = RTC_NUM_REGS,
  parameter int AW    = 5
)(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [7:0]    wr_data,
  // read port
  input  wire logic [AW-1:0] rd_idx,
  output logic [7:0]         rd_data,
  // whole contents for the decoders
  output logic [7:0]         mem_flat [DEPTH]
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_flat[i] <= RTC_REG_RESET;
      rd_data <= RTC_REG_RESET;
    end
    else
    begin
      if (wr_en && (int'(wr_idx) < DEPTH))
        mem_flat[wr_idx] <= wr_data;
      rd_data <= (int'(rd_idx) < DEPTH) ? mem_flat[rd_idx] : RTC_REG_RESET;
    end
  end

endmodule

/* File: design/rtc_config_bank.sv */
// rtc_config_bank: configuration and status register bank of the
// transmitter, with field decode, clock-out divider chain and status.
// assumes: serial link front end gives byte writes/read requests,
// all inputs synchronous to ref_clk.
//
// What this block does
// - integer code n gives feedback divider integer sixteen plus n
// - two integer codes a byte: odd channel high nibble, even low
// - 16-bit fraction for channels 3 and 4, high byte at lower address
// - one output divider bit per channel, channel 1 highest; 1 halves
// - deviation is code over 2^16 of reference, times 4 and 2 flags
// - divider register bits 5:4 give clock pin edge rate, 0 slowest
// - modulation registers: bit 7 type ask, bit 6 high power range
// - six-bit high level drives high ask bits or fsk constant level
// - transmit selector 0 uses first modulation set, 1 the second
// - duty codes map 50/45/36/30 percent; upper band only 50/45
// - low level drives low ask bits; zero switches amplifier off in ask mode
// - ask ramp time is level difference times ask ramp code
// - fsk ramp time is out divider times two times deviation times code
// - compare stage divides by compare code plus one
// - three-bit source code selects clock pin drive, codes 010, 011 and 1xx gated by amp
// - prescaler divides by two to the prescaler code
// - final stage divides by two to the final stage code
// - bits 6:5 pick undervoltage thresholds, 4:0 antenna trim
// - status bits 7:4 count transmit entries, wrapping on overflow
// - status write or power-down clears counter and clearable flags
// - status 3:0: osc ok, undervolt, vco cal error, lock loss
`timescale 1ns/1ns
module rtc_config_bank
  import rtc_pkg::*;
#(
  parameter int AW = 5
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // register access from the serial front end
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // device mode and event inputs
  input  wire logic        tx_select,
  input  wire logic        tx_entry,
  input  wire logic        power_down,
  input  wire logic        amp_enabled,
  input  wire logic        upper_band,
  input  wire logic        osc_amplitude_ok,
  input  wire logic        undervolt_event,
  input  wire logic        vco_cal_event,
  input  wire logic        lock_loss_event,
  // decoded channel settings
  output logic [4:0]       chan1_feedback_int,
  output logic [4:0]       chan2_feedback_int,
  output logic [4:0]       chan3_feedback_int,
  output logic [4:0]       chan4_feedback_int,
  output logic [15:0]      chan3_fraction_word,
  output logic [15:0]      chan4_fraction_word,
  output logic [3:0]       chan_out_halve,
  // modulation settings
  output logic [10:0]      deviation_scaled,
  output logic [1:0]       clock_pin_edge_rate,
  output logic             mod_is_ask,
  output logic             power_range_high,
  output logic [5:0]       amp_high_level,
  output logic [5:0]       amp_low_level,
  output logic             amp_off_keying,
  output logic [1:0]       amp_duty_sel,
  output logic             duty_invalid,
  output logic [13:0]      ask_ramp_periods,
  output logic [18:0]      fsk_ramp_periods,
  // supply and antenna
  output logic [1:0]       undervolt_threshold_sel,
  output logic [4:0]       antenna_cap_trim,
  // clock output pin and bitrate tick
  output logic             clock_out_pin,
  output logic             clock_out_oe_n,
  output logic             bitrate_tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  entry_count;
    logic        uv_flag;
    logic        vco_flag;
    logic        lock_flag;
    logic        osc_ok;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [6:0]  ref_div;
    logic        presc_clk;
    logic [7:0]  cmp_cnt;
    logic [2:0]  aft_cnt;
    logic        div_clk;
    logic        pin;
    logic        pin_oe_n;
    logic        tick;
    logic [4:0]  f1;
    logic [4:0]  f2;
    logic [4:0]  f3;
    logic [4:0]  f4;
    logic [15:0] fr3;
    logic [15:0] fr4;
    logic [3:0]  halve;
    logic [10:0] dev;
    logic [1:0]  edge_rate;
    logic        ask;
    logic        hirange;
    logic [5:0]  hlvl;
    logic [5:0]  llvl;
    logic        ook;
    logic [1:0]  duty;
    logic        duty_bad;
    logic [13:0] aramp;
    logic [18:0] framp;
    logic [1:0]  uvsel;
    logic [4:0]  trim;
  } rtc_state_s;

  rtc_state_s st_reg;
  rtc_state_s st_next;

  logic [7:0]    mem_flat [RTC_NUM_REGS];
  logic          mem_wr;
  logic [AW-1:0] mem_widx;
  logic [7:0]    mem_wdata;
  logic [AW-1:0] mem_ridx;

  function automatic logic [AW-1:0] reg_index(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - RTC_FIRST_ADDR;
    return d[AW-1:0];
  endfunction

  function automatic logic in_map(input logic [7:0] addr);
    return (addr >= RTC_FIRST_ADDR) && (addr <= RTC_TRANSMIT_STATUS);
  endfunction

  function automatic logic [7:0] reg_of(input logic [7:0] addr);
    return mem_flat[reg_index(addr)];
  endfunction

  function automatic logic [4:0] feedback_int(input logic [3:0] code);
    return RTC_INT_BASE + {1'b0, code};
  endfunction

  // ---------------------------------------------------------------
  // register store
  // ---------------------------------------------------------------
  assign mem_wr    = reg_wr && in_map(reg_addr) && (reg_addr != RTC_TRANSMIT_STATUS);
  assign mem_widx  = reg_index(reg_addr);
  assign mem_wdata = (reg_addr == RTC_UNDERVOLT_ANT_TRIM) ? (reg_wdata & RTC_TRIM_MASK)
                                                         : reg_wdata;
  assign mem_ridx  = reg_index(reg_addr);

  rtc_reg_mem #(
    .DEPTH (RTC_NUM_REGS),
    .AW    (AW)
  ) u_mem (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .wr_en    (mem_wr),
    .wr_idx   (mem_widx),
    .wr_data  (mem_wdata),
    .rd_idx   (mem_ridx),
    .rd_data  (),
    .mem_flat (mem_flat)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  r_int12;
    logic [7:0]  r_int34;
    logic [7:0]  r_out_divider_and_slew;
    logic [7:0]  r_dev;
    logic [7:0]  r_mod;
    logic [7:0]  r_duty;
    logic [7:0]  r_cmp;
    logic [7:0]  r_src;
    logic [7:0]  r_trim;
    logic [2:0]  src;
    logic [2:0]  prescaler_ratio;
    logic [1:0]  final_stage_ratio;
    logic [6:0]  pmask;
    logic        pre_tick;
    logic        cmp_tick;
    logic [2:0]  amask;
    logic        chosen;
    logic [5:0]  ldiff;
    logic [1:0]  out_divider_and_slew;
    logic        clr;
    r_int12  = reg_of(RTC_CHAN12_INTEGER);
    r_int34  = reg_of(RTC_CHAN34_INTEGER);
    r_out_divider_and_slew   = reg_of(RTC_OUT_DIVIDER_AND_SLEW);
    r_dev    = reg_of(RTC_FSK_DEVIATION_CODE);
    r_mod    = tx_select ? reg_of(RTC_MODULATION_SET_B)
                         : reg_of(RTC_MODULATION_SET_A);
    r_duty   = reg_of(RTC_DUTY_AND_LOW_LEVEL);
    r_cmp    = reg_of(RTC_DIVIDER_COMPARE);
    r_src    = reg_of(RTC_CLOCK_SOURCE_SCALERS);
    r_trim   = reg_of(RTC_UNDERVOLT_ANT_TRIM);
    src      = r_src[RTC_SRC_LSB +: 3];
    prescaler_ratio      = r_src[RTC_PSC_LSB +: 3];
    final_stage_ratio      = r_src[1:0];
    out_divider_and_slew     = 2'h1 + {1'b0, tx_select ? r_out_divider_and_slew[2] : r_out_divider_and_slew[3]};
    chosen   = 1'b0;
    st_next  = st_reg;

    // decoded settings
    st_next.f1    = feedback_int(r_int12[RTC_ODD_CHAN_LSB +: 4]);
    st_next.f2    = feedback_int(r_int12[3:0]);
    st_next.f3    = feedback_int(r_int34[RTC_ODD_CHAN_LSB +: 4]);
    st_next.f4    = feedback_int(r_int34[3:0]);
    st_next.fr3   = {reg_of(RTC_CHAN3_FRACTION_HIGH), reg_of(RTC_CHAN3_FRACTION_LOW)};
    st_next.fr4   = {reg_of(RTC_CHAN4_FRACTION_HIGH), reg_of(RTC_CHAN4_FRACTION_LOW)};
    st_next.halve = r_out_divider_and_slew[3:0];
    st_next.dev   = 11'({3'h0, r_dev} << ({1'b0, r_out_divider_and_slew[RTC_DEV_QUAD_BIT], 1'b0}
                    + {2'h0, r_out_divider_and_slew[RTC_DEV_DOUBLE_BIT]}));
    st_next.edge_rate = r_out_divider_and_slew[RTC_EDGE_LSB +: 2];
    st_next.ask     = r_mod[RTC_MOD_TYPE_BIT];
    st_next.hirange = r_mod[RTC_RANGE_BIT];
    st_next.hlvl    = r_mod[5:0];
    st_next.llvl    = r_duty[5:0];
    st_next.ook     = (r_duty[5:0] == 6'h00) && r_mod[RTC_MOD_TYPE_BIT];
    st_next.duty    = r_duty[RTC_DUTY_LSB +: 2];
    st_next.duty_bad = upper_band && (r_duty[RTC_DUTY_LSB +: 2] != RTC_DUTY_50)
                       && (r_duty[RTC_DUTY_LSB +: 2] != RTC_DUTY_45);
    ldiff = (r_mod[5:0] > r_duty[5:0]) ? (r_mod[5:0] - r_duty[5:0]) : 6'h00;
    st_next.aramp = 14'(ldiff) * 14'(reg_of(RTC_ASK_RAMP_CONTROL));
    st_next.framp = 19'(out_divider_and_slew) * 19'h2 * 19'(r_dev) * 19'(reg_of(RTC_FSK_RAMP_CONTROL));
    st_next.uvsel = r_trim[RTC_UNDERVOLT_THRESHOLD_SEL_LSB +: 2];
    st_next.trim  = r_trim[4:0];

    // divider chain
    st_next.ref_div = st_reg.ref_div + 7'h01;
    pmask    = 7'((8'h01 << prescaler_ratio) - 8'h01);
    pre_tick = (prescaler_ratio == 3'h0) || ((st_reg.ref_div & pmask) == pmask);
    st_next.presc_clk = (prescaler_ratio == 3'h0) ? ~st_reg.presc_clk : st_reg.ref_div[prescaler_ratio - 3'h1];
    cmp_tick = 1'b0;
    if (pre_tick)
    begin
      if (st_reg.cmp_cnt >= r_cmp)
      begin
        st_next.cmp_cnt = 8'h00;
        cmp_tick = 1'b1;
      end
      else
        st_next.cmp_cnt = st_reg.cmp_cnt + 8'h01;
    end
    amask = 3'((4'h1 << final_stage_ratio) - 4'h1);
    st_next.tick = 1'b0;
    if (cmp_tick)
    begin
      st_next.aft_cnt = st_reg.aft_cnt + 3'h1;
      if ((st_reg.aft_cnt & amask) == amask)
      begin
        st_next.aft_cnt = 3'h0;
        st_next.div_clk = ~st_reg.div_clk;
        st_next.tick    = 1'b1;
      end
    end

    // clock pin source
    case (rtc_src_e'(src[1:0]))
      RTC_SRC_REF16:   chosen = st_reg.ref_div[RTC_REF_DIV_LOG2 - 1];
      RTC_SRC_PRESCL:  chosen = st_reg.presc_clk;
      RTC_SRC_DIVIDED: chosen = st_reg.div_clk;
      default:         chosen = ~st_reg.div_clk;
    endcase
    if (src[2])
    begin
      st_next.pin      = amp_enabled ? chosen : 1'b1;
      st_next.pin_oe_n = ~amp_enabled;
    end
    else
    begin
      st_next.pin_oe_n = 1'b0;
      if ((src[1:0] == 2'h2) && !amp_enabled)
        st_next.pin = 1'b0;
      else if ((src[1:0] == 2'h3) && !amp_enabled)
        st_next.pin = 1'b1;
      else
        st_next.pin = chosen;
    end

    // status: clear then set, so a same-cycle event survives
    clr = power_down || (reg_wr && (reg_addr == RTC_TRANSMIT_STATUS));
    if (clr)
    begin
      st_next.entry_count = 4'h0;
      st_next.uv_flag     = 1'b0;
      st_next.vco_flag    = 1'b0;
      st_next.lock_flag   = 1'b0;
    end
    if (tx_entry)
      st_next.entry_count = (clr ? 4'h0 : st_reg.entry_count) + 4'h1;
    if (undervolt_event)
      st_next.uv_flag = 1'b1;
    if (vco_cal_event)
      st_next.vco_flag = 1'b1;
    if (lock_loss_event)
      st_next.lock_flag = 1'b1;
    st_next.osc_ok = osc_amplitude_ok;

    // read pipeline
    st_next.rvalid = reg_rd;
    if (!in_map(reg_addr))
      st_next.rdata = RTC_REG_RESET;
    else if (reg_addr == RTC_TRANSMIT_STATUS)
      st_next.rdata = {st_reg.entry_count, st_reg.osc_ok, st_reg.uv_flag,
                       st_reg.vco_flag, st_reg.lock_flag};
    else
      st_next.rdata = reg_of(reg_addr);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata               = st_reg.rdata;
  assign reg_rvalid              = st_reg.rvalid;
  assign chan1_feedback_int      = st_reg.f1;
  assign chan2_feedback_int      = st_reg.f2;
  assign chan3_feedback_int      = st_reg.f3;
  assign chan4_feedback_int      = st_reg.f4;
  assign chan3_fraction_word     = st_reg.fr3;
  assign chan4_fraction_word     = st_reg.fr4;
  assign chan_out_halve          = st_reg.halve;
  assign deviation_scaled        = st_reg.dev;
  assign clock_pin_edge_rate     = st_reg.edge_rate;
  assign mod_is_ask              = st_reg.ask;
  assign power_range_high        = st_reg.hirange;
  assign amp_high_level          = st_reg.hlvl;
  assign amp_low_level           = st_reg.llvl;
  assign amp_off_keying          = st_reg.ook;
  assign amp_duty_sel            = st_reg.duty;
  assign duty_invalid            = st_reg.duty_bad;
  assign ask_ramp_periods        = st_reg.aramp;
  assign fsk_ramp_periods        = st_reg.framp;
  assign undervolt_threshold_sel = st_reg.uvsel;
  assign antenna_cap_trim        = st_reg.trim;
  assign clock_out_pin           = st_reg.pin;
  assign clock_out_oe_n          = st_reg.pin_oe_n;
  assign bitrate_tick            = st_reg.tick;

endmodule

/* File: verif/rtc_config_monitor.sv */
// rtc_config_monitor: port level assertions of the configuration bank
// assumes: bound to rtc_config_bank, one ref_clk domain, srst synchronous
`timescale 1ns/1ns
module rtc_config_monitor
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // register access
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // decoded settings
  input wire logic [4:0]  chan1_feedback_int,
  input wire logic [4:0]  chan2_feedback_int,
  input wire logic [15:0] chan3_fraction_word,
  input wire logic [3:0]  chan_out_halve,
  input wire logic [1:0]  clock_pin_edge_rate,
  input wire logic        mod_is_ask,
  input wire logic [5:0]  amp_low_level,
  input wire logic        amp_off_keying,
  input wire logic [1:0]  amp_duty_sel,
  input wire logic        duty_invalid,
  input wire logic [1:0]  undervolt_threshold_sel,
  input wire logic [4:0]  antenna_cap_trim,
  // clock pin
  input wire logic        clock_out_pin,
  input wire logic        clock_out_oe_n
);
  // ----------------------------------------
  // write pipeline and clock source shadow
  // ----------------------------------------
  logic [16:0] pipe1_reg;
  logic [16:0] pipe2_reg;
  logic [2:0]  src_reg;

  always_ff @(posedge ref_clk)
  begin
    pipe1_reg <= srst ? 17'h0 : {reg_wr, reg_addr, reg_wdata};
    pipe2_reg <= srst ? 17'h0 : pipe1_reg;
    if (srst)
      src_reg <= 3'h0;
    else if (reg_wr && reg_addr == RTC_CLOCK_SOURCE_SCALERS)
      src_reg <= reg_wdata[7:5];
  end

  wire logic       w2 = pipe2_reg[16];
  wire logic [7:0] a2 = pipe2_reg[15:8];
  wire logic [7:0] d2 = pipe2_reg[7:0];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_INT_DECODE: assert property (
    w2 && a2 == RTC_CHAN12_INTEGER |-> chan1_feedback_int == {1'b1, d2[7:4]}
      && chan2_feedback_int == {1'b1, d2[3:0]}) else $error("integer decode wrong");
  AST_FRACTION: assert property (
    w2 && a2 == RTC_CHAN3_FRACTION_HIGH |-> chan3_fraction_word[15:8] == d2)
    else $error("fraction high byte wrong");
  AST_HALVE: assert property (
    w2 && a2 == RTC_OUT_DIVIDER_AND_SLEW |-> chan_out_halve == d2[3:0])
    else $error("output halve bits wrong");
  AST_EDGE_RATE: assert property (
    w2 && a2 == RTC_OUT_DIVIDER_AND_SLEW |-> clock_pin_edge_rate == d2[5:4])
    else $error("edge rate wrong");
  AST_TRIM: assert property (
    w2 && a2 == RTC_UNDERVOLT_ANT_TRIM |-> undervolt_threshold_sel == d2[6:5]
      && antenna_cap_trim == d2[4:0]) else $error("threshold or trim wrong");
  AST_TOP_BIT_ZERO: assert property (
    reg_rvalid && $past(reg_addr) == RTC_UNDERVOLT_ANT_TRIM |-> !reg_rdata[7])
    else $error("unused trim bit read back set");
  AST_OFF_KEYING: assert property (
    amp_off_keying == (mod_is_ask && amp_low_level == 6'h0)) else $error("off keying wrong");
  AST_DUTY: assert property (
    duty_invalid |-> amp_duty_sel[1]) else $error("duty flagged for valid code");
  AST_SRC_DRIVEN: assert property (
    !src_reg[2] && !$past(src_reg[2]) && !$past(src_reg[2], 2) |-> !clock_out_oe_n)
    else $error("clock pin released for source 0xx");
  AST_HIGHZ_LEVEL: assert property (
    clock_out_oe_n |-> clock_out_pin) else $error("released clock pin not high");
endmodule

bind rtc_config_bank rtc_config_monitor rtc_config_monitor_inst (.*);

/* File: verif/rtc_host_model.sv */
// rtc_host_model: controller side issuing byte writes and read requests
// assumes: tasks called from the bench, read data watched by the bench
`timescale 1ns/1ns
module rtc_host_model
(
  // clock
  input wire logic   ref_clk,
  // register access
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one strobe cycle; released lines show inverted garbage
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

/* File: verif/rtc_config_bank_tb.sv */
// rtc_config_bank_tb: self-checking bench of the configuration bank
// assumes: rtc_host_model makes the accesses, 125 MHz ref_clk
`timescale 1ns/1ns
module rtc_config_bank_tb
  import rtc_pkg::*;
  ;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        tx_select = 1'b0, tx_entry = 1'b0, power_down = 1'b0, amp_enabled = 1'b0;
  logic        upper_band = 1'b0, osc_amplitude_ok = 1'b0;
  logic        undervolt_event = 1'b0, vco_cal_event = 1'b0, lock_loss_event = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, mod_is_ask, power_range_high, amp_off_keying;
  logic        duty_invalid, clock_out_pin, clock_out_oe_n, bitrate_tick;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, hi, lo;
  logic [4:0]  chan1_feedback_int, chan2_feedback_int, chan3_feedback_int, chan4_feedback_int;
  logic [15:0] chan3_fraction_word, chan4_fraction_word;
  logic [3:0]  chan_out_halve;
  logic [10:0] deviation_scaled;
  logic [1:0]  clock_pin_edge_rate, amp_duty_sel, undervolt_threshold_sel;
  logic [5:0]  amp_high_level, amp_low_level;
  logic [13:0] ask_ramp_periods;
  logic [18:0] fsk_ramp_periods;
  logic [4:0]  antenna_cap_trim;
  logic [7:0]  mem [32];
  logic [7:0]  exp_q [$];
  int          n_errors = 0, comparisons = 0, p1;

  rtc_config_bank rtc_config_bank_inst (.*);
  rtc_host_model rtc_host_model_inst (.*);

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    rtc_host_model_inst.xfer(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    rtc_host_model_inst.xfer(1'b0, a, 8'h00);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic per(output int p);
    p = 0;
    do
    begin
      @(negedge ref_clk);
      p++;
    end
    while (bitrate_tick !== 1'b1 && p < 2000);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // read data against the oldest note
  always @(posedge ref_clk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 32'h1, 32'h0);
      else
        chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  initial
  begin
    #160000;
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    p1 = $urandom(79169);
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 4; a <= 20; a++)
      rd(8'(a), RTC_REG_RESET);
    chk("chan1_int", 5'h10, chan1_feedback_int);
    for (int r = 0; r < 2; r++)
    begin
      for (int a = 4; a < 20; a++)
      begin
        d = 8'($urandom());
        if (r == 1 && (a == 12 || a == 13)) d[7] = 1'b1;
        if (r == 1 && a == 14) d = {1'b1, d[6], 6'h0};
        mem[a] = (a == 19) ? (d & RTC_TRIM_MASK) : d;
        wr(8'(a), d);
        rd(8'(a), mem[a]);
      end
      settle();
      chk("chan1_int", {1'b1, mem[4][7:4]}, chan1_feedback_int);
      chk("chan2_int", {1'b1, mem[4][3:0]}, chan2_feedback_int);
      chk("chan3_int", {1'b1, mem[9][7:4]}, chan3_feedback_int);
      chk("chan4_int", {1'b1, mem[9][3:0]}, chan4_feedback_int);
      chk("chan3_frac", {mem[5], mem[6]}, chan3_fraction_word);
      chk("chan4_frac", {mem[7], mem[8]}, chan4_fraction_word);
      chk("out_halve", mem[10][3:0], chan_out_halve);
      chk("edge_rate", mem[10][5:4], clock_pin_edge_rate);
      chk("deviation", 11'(mem[11]) << (2 * mem[10][7] + mem[10][6]), deviation_scaled);
      chk("uv_sel", mem[19][6:5], undervolt_threshold_sel);
      chk("ant_trim", mem[19][4:0], antenna_cap_trim);
      for (int k = 0; k < 4; k++)
      begin
        @(posedge ref_clk);
        tx_select <= k[0];
        upper_band <= k[1];
        settle();
        hi = mem[12 + k[0]];
        lo = mem[14];
        chk("mod_ask", hi[7], mod_is_ask);
        chk("range", hi[6], power_range_high);
        chk("high_level", hi[5:0], amp_high_level);
        chk("low_level", lo[5:0], amp_low_level);
        chk("off_keying", hi[7] && lo[5:0] == 6'h0, amp_off_keying);
        chk("duty", lo[7:6], amp_duty_sel);
        chk("duty_invalid", k[1] && lo[7], duty_invalid);
        chk("ask_ramp", (hi[5:0] > lo[5:0] ? hi[5:0] - lo[5:0] : 0) * mem[15], ask_ramp_periods);
        chk("fsk_ramp", (mem[10][3 - k[0]] ? 4 : 2) * mem[11] * mem[16], fsk_ramp_periods);
      end
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(RTC_CLOCK_SOURCE_SCALERS, 8'(c << 5));
      settle();
      chk("pin_oe_n", c[2], clock_out_oe_n);
      if (c >= 2) chk("pin_level", c != 2, clock_out_pin);
    end
    @(posedge ref_clk);
    amp_enabled <= 1'b1;
    settle();
    chk("pin_oe_n", 1'b0, clock_out_oe_n);
    for (int t = 0; t < 4; t++)
    begin
      wr(RTC_DIVIDER_COMPARE, (t == 1) ? 8'h03 : 8'h01);
      wr(RTC_CLOCK_SOURCE_SCALERS, (t == 2) ? 8'h0d : (t == 3) ? 8'h07 : 8'h05);
      repeat (3) per(p1);
      chk("tick_period", (t == 0) ? 8 : (t == 1) ? 16 : 32, p1);
    end
    @(posedge ref_clk);
    osc_amplitude_ok <= 1'b1;
    repeat (17)
    begin
      @(posedge ref_clk);
      tx_entry <= 1'b1;
      @(posedge ref_clk);
      tx_entry <= 1'b0;
    end
    for (int e = 0; e < 3; e++)
    begin
      @(posedge ref_clk);
      {undervolt_event, vco_cal_event, lock_loss_event} <= 3'(4 >> e);
      @(posedge ref_clk);
      {undervolt_event, vco_cal_event, lock_loss_event} <= 3'h0;
      rd(RTC_TRANSMIT_STATUS, 8'h18 | 8'(7 << (2 - e)) & 8'h07);
    end
    wr(RTC_TRANSMIT_STATUS, 8'($urandom()));
    rd(RTC_TRANSMIT_STATUS, 8'h08);
    @(posedge ref_clk);
    {tx_entry, undervolt_event} <= 2'h3;
    @(posedge ref_clk);
    {tx_entry, undervolt_event} <= 2'h0;
    rd(RTC_TRANSMIT_STATUS, 8'h1c);
    @(posedge ref_clk);
    power_down <= 1'b1;
    @(posedge ref_clk);
    power_down <= 1'b0;
    rd(RTC_TRANSMIT_STATUS, 8'h08);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    rd(8'h15, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk("pending_reads", 32'h0, exp_q.size());
    print_verdict();
  end
endmodule
